// ### rtl/sbsc_pkg.sv
// Package with widths, lane layout, burst modes and command encodings for the SRAM input front end.
package sbsc_pkg;
   localparam int SBSC_LANES = 8;
   localparam int SBSC_LANE_BITS = 8;
   localparam int SBSC_DATA_BITS = 64;
   localparam int SBSC_ADDR_BITS = 20;
   localparam int SBSC_BURST_BITS = 2;
   localparam int SBSC_FIFO_DEPTH = 32;
   localparam int SBSC_MEM_WORDS = 16;
   localparam logic [1:0] SBSC_BURST_ONE = 2'h1;
   localparam logic [7:0] SBSC_LANES_ALL_OFF = 8'hff;
   // Burst order from the strap: high or floating is interleaved, low is linear.
   localparam logic SBSC_ORDER_INTERLEAVED = 1'h1;

   typedef enum logic [2:0] {
      SBSC_CMD_IDLE = 3'h1,
      SBSC_CMD_WRITE = 3'h2,
      SBSC_CMD_ADV = 3'h4
   } sbsc_cmd_t;

   // Next burst address in either order; used by the SRAM end only.
   function automatic logic [1:0] sbsc_next_burst(input logic [1:0] start,
                                                   input logic [1:0] step,
                                                   input logic interleaved);
      logic [1:0] nstep;
      nstep = step + SBSC_BURST_ONE;
      if (interleaved) begin
         sbsc_next_burst = start ^ nstep;
      end else begin
         sbsc_next_burst = start + nstep;
      end
   endfunction
endpackage

// ### rtl/sbsc_bus_if.sv
// Interface joining the memory controller end to the SRAM input front end.
`timescale 1ns/1ps
interface sbsc_bus_if;
   logic clock_qualify_n;
   logic [19:0] addr;
   logic advance_or_load_n;
   logic write_en_n;
   logic chip_select_first_n;
   logic [7:0] byte_write_sel_n;
   logic [63:0] data_from_ctrl;
   logic [7:0] parity_from_ctrl;
   logic [63:0] data_from_sram;
   logic [7:0] parity_from_sram;
   logic [7:0] sram_drive_en;
   modport ctrl (
      output clock_qualify_n, addr, advance_or_load_n, write_en_n, chip_select_first_n,
      output byte_write_sel_n, data_from_ctrl, parity_from_ctrl,
      input data_from_sram, parity_from_sram, sram_drive_en
   );
   modport sram (
      input clock_qualify_n, addr, advance_or_load_n, write_en_n, chip_select_first_n,
      input byte_write_sel_n, data_from_ctrl, parity_from_ctrl,
      output data_from_sram, parity_from_sram, sram_drive_en
   );
endinterface

// ### rtl/sbsc_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sbsc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock, reset, enable.
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   // Fill side.
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side.
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign in_ready_out = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];

   always_comb begin
      push = ce_in && in_valid_in && in_ready_out;
      pop = ce_in && out_valid_out && out_ready_in;
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end
endmodule

// ### rtl/sbsc_ctrl_end.sv
// Memory controller end: turns queued write requests into bus cycles.
`timescale 1ns/1ps
module sbsc_ctrl_end
   import sbsc_pkg::*;
#(
   parameter int DEPTH = SBSC_FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Request side: address, lane mask (1 = write), data, parity, burst continue.
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [19:0] req_addr_in,
   input wire logic [7:0] req_lanes_in,
   input wire logic [63:0] req_data_in,
   input wire logic [7:0] req_parity_in,
   input wire logic req_advance_in,
   input wire logic stall_in,
   // Bus.
   sbsc_bus_if.ctrl bus
);
   localparam int W = 20 + 8 + 64 + 8 + 1;
   logic q_valid;
   logic [W-1:0] q_data;
   logic selected, next_selected;
   logic [19:0] q_addr;
   logic [7:0] q_lanes;
   logic [63:0] q_wdata;
   logic [7:0] q_par;
   logic q_adv;

   sbsc_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .ce_in(1'b1),
      .in_valid_in(req_valid_in),
      .in_ready_out(req_ready_out),
      .in_data_in({req_addr_in, req_lanes_in, req_data_in, req_parity_in, req_advance_in}),
      .out_valid_out(q_valid),
      .out_ready_in(!stall_in),
      .out_data_out(q_data)
   );

   assign {q_addr, q_lanes, q_wdata, q_par, q_adv} = q_data;

   always_comb begin
      next_selected = selected;
      if (!stall_in) begin
         next_selected = q_valid;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         selected <= 1'b0;
      end else begin
         selected <= next_selected;
      end
   end

   // Stall suspends the bus by holding the clock qualifier high.
   assign bus.clock_qualify_n = stall_in;
   assign bus.chip_select_first_n = !q_valid;
   assign bus.addr = q_addr;
   // A burst may only continue while selected; after deselect a load is forced.
   assign bus.advance_or_load_n = q_adv && selected;
   assign bus.write_en_n = !q_valid;
   assign bus.byte_write_sel_n = ~q_lanes;
   assign bus.data_from_ctrl = q_wdata;
   assign bus.parity_from_ctrl = q_par;
endmodule

// ### rtl/sbsc_sram_end.sv
// SRAM end: registered control inputs, burst counter, byte-lane writes, output masking.
//Contract
//- Capture all address bits on rising edge.
//- Byte selects active low, need write enable.
//- Eight lanes each gate byte and parity.
//- Write enable sampled only when qualified.
//- Controller drives write enable low to write.
//- Advance high steps the burst counter.
//- Advance low loads a new address.
//- After deselect controller must load address.
//- Qualifier high holds all state, no deselect; the code still takes the strap on the first edge after reset.
//- Strap selects interleaved or linear order.
//- Outputs off on write, deselect, first cycle.
//- Only qualified edges capture inputs; the code takes the strap on the first edge after reset, qualified or not.
`timescale 1ns/1ps
module sbsc_sram_end
   import sbsc_pkg::*;
#(
   parameter int WORDS = SBSC_MEM_WORDS
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Static burst order strap and read request.
   input wire logic burst_order_in,
   input wire logic read_en_n_in,
   // Bus.
   sbsc_bus_if.sram bus,
   // Status.
   output logic [19:0] cur_addr_out,
   output logic write_pulse_out
);
   localparam int IW = $clog2(WORDS);
   logic qual;
   logic [19:0] base_addr, next_base_addr;
   logic [1:0] step, next_step;
   logic selected, next_selected;
   logic was_selected, next_was_selected;
   logic wr_cycle, next_wr_cycle;
   logic [7:0] lanes, next_lanes;
   logic strap, next_strap, strap_taken, next_strap_taken;
   logic [63:0] mem_data [WORDS];
   logic [7:0] mem_par [WORDS];
   logic [63:0] rdata, next_rdata;
   logic [7:0] rpar, next_rpar;
   logic [19:0] eff_addr;
   logic [IW-1:0] idx;
   logic [19:0] wr_addr;
   logic [IW-1:0] wr_idx;

   assign qual = !bus.clock_qualify_n;
   assign eff_addr = {base_addr[19:2],
                      strap ? base_addr[1:0] ^ step : 2'(base_addr[1:0] + step)};
   assign idx = eff_addr[IW-1:0];
   // A write lands at the address that this same edge loads or advances to.
   assign wr_addr = bus.advance_or_load_n
                    ? {base_addr[19:2], sbsc_next_burst(base_addr[1:0], step, strap)}
                    : bus.addr;
   assign wr_idx = wr_addr[IW-1:0];

   always_comb begin
      next_base_addr = base_addr;
      next_step = step;
      next_selected = selected;
      next_was_selected = was_selected;
      next_wr_cycle = wr_cycle;
      next_lanes = lanes;
      next_strap = strap;
      next_strap_taken = 1'b1;
      next_rdata = rdata;
      next_rpar = rpar;
      if (!strap_taken) begin
         next_strap = burst_order_in;
      end
      if (qual) begin
         next_was_selected = selected;
         next_selected = !bus.chip_select_first_n;
         if (!bus.chip_select_first_n) begin
            if (bus.advance_or_load_n) begin
               next_step = sbsc_next_burst(2'h0, step, 1'b0);
            end else begin
               next_base_addr = bus.addr;
               next_step = '0;
            end
         end
         next_wr_cycle = !bus.write_en_n && !bus.chip_select_first_n;
         next_lanes = bus.write_en_n ? SBSC_LANES_ALL_OFF : bus.byte_write_sel_n;
         next_rdata = mem_data[idx];
         next_rpar = mem_par[idx];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         base_addr <= '0;
         step <= '0;
         selected <= 1'b0;
         was_selected <= 1'b0;
         wr_cycle <= 1'b0;
         lanes <= SBSC_LANES_ALL_OFF;
         strap <= SBSC_ORDER_INTERLEAVED;
         strap_taken <= 1'b0;
         rdata <= '0;
         rpar <= '0;
      end else begin
         base_addr <= next_base_addr;
         step <= next_step;
         selected <= next_selected;
         was_selected <= next_was_selected;
         wr_cycle <= next_wr_cycle;
         lanes <= next_lanes;
         strap <= next_strap;
         strap_taken <= next_strap_taken;
         rdata <= next_rdata;
         rpar <= next_rpar;
      end
   end

   // Write data lands on the same qualified edge as the command, lane by lane.
   always_ff @(posedge clk_in) begin
      for (int l = 0; l < SBSC_LANES; l++) begin
         if (qual && !bus.write_en_n && !bus.chip_select_first_n
             && !bus.byte_write_sel_n[l]) begin
            mem_data[wr_idx][l*SBSC_LANE_BITS +: SBSC_LANE_BITS] <=
               bus.data_from_ctrl[l*SBSC_LANE_BITS +: SBSC_LANE_BITS];
            mem_par[wr_idx][l] <= bus.parity_from_ctrl[l];
         end
      end
   end

   assign bus.data_from_sram = rdata;
   assign bus.parity_from_sram = rpar;
   assign bus.sram_drive_en = (selected && was_selected && !wr_cycle && !read_en_n_in)
                              ? ~SBSC_LANES_ALL_OFF : '0;
   assign cur_addr_out = eff_addr;
   assign write_pulse_out = qual && !bus.write_en_n && !bus.chip_select_first_n;
endmodule

// ### tb/sbsc_checker.sv
// Checker for the bus between the controller end and the SRAM end.
`timescale 1ns/1ps
module sbsc_checker (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Bus.
   input wire logic clock_qualify_n,
   input wire logic [19:0] addr,
   input wire logic advance_or_load_n,
   input wire logic write_en_n,
   input wire logic chip_select_first_n,
   input wire logic [7:0] byte_write_sel_n,
   input wire logic [63:0] data_from_sram,
   input wire logic [7:0] sram_drive_en
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   logic was_desel;
   logic next_was_desel;
   always_comb begin
      next_was_desel = clock_qualify_n ? was_desel : chip_select_first_n;
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         was_desel <= 1'h1;
      end else begin
         was_desel <= next_was_desel;
      end
   end
   load_after_desel_a: assert property (!chip_select_first_n && was_desel |-> !advance_or_load_n)
      else $error("advance issued right after deselect");
   write_with_sel_a: assert property (write_en_n == chip_select_first_n)
      else $error("write enable does not follow select");
   desel_drive_off_a: assert property (!clock_qualify_n && chip_select_first_n |=> sram_drive_en == 8'h00)
      else $error("data driven while deselected");
   write_drive_off_a: assert property (!clock_qualify_n && !write_en_n |=> sram_drive_en == 8'h00)
      else $error("data driven after write");
   first_sel_off_a: assert property (!clock_qualify_n && !chip_select_first_n && was_desel |=> sram_drive_en == 8'h00)
      else $error("data driven leaving deselect");
   drive_whole_a: assert property (sram_drive_en == 8'h00 || sram_drive_en == 8'hff)
      else $error("partial drive enable");
   stall_data_a: assert property (clock_qualify_n |=> $stable(data_from_sram) && $stable(sram_drive_en))
      else $error("read side changed on ignored edge");
   stall_cmd_a: assert property (clock_qualify_n && !chip_select_first_n |=> !chip_select_first_n && $stable(addr) && $stable(byte_write_sel_n))
      else $error("command changed during stall");
   cover property (clock_qualify_n && !chip_select_first_n);
   cover property (!clock_qualify_n && !chip_select_first_n && advance_or_load_n);
   cover property (!chip_select_first_n && was_desel);
endmodule

// ### tb/sync_burst_sram_ctrl_inputs_tb.sv
// Testbench joining the controller end to the SRAM end through the bus interface.
`timescale 1ns/1ps
module sync_burst_sram_ctrl_inputs_tb
   import sbsc_pkg::*;
;
   typedef struct {
      logic [19:0] a;
      logic [7:0] l;
      logic adv;
      logic [19:0] e_int;
      logic [19:0] e_lin;
   } sbsc_row_t;
   sbsc_row_t rows [6] = '{
      '{20'h12345, 8'h01, 1'h0, 20'h12345, 20'h12345},
      '{20'h00000, 8'h80, 1'h1, 20'h12344, 20'h12346},
      '{20'h00000, 8'hff, 1'h1, 20'h12347, 20'h12347},
      '{20'h00000, 8'h5a, 1'h1, 20'h12346, 20'h12344},
      '{20'habcde, 8'ha5, 1'h0, 20'habcde, 20'habcde},
      '{20'h00000, 8'h3c, 1'h1, 20'habcdf, 20'habcdf}
   };
   logic clk_in = 1'h0;
   logic rstn_in = 1'h0;
   logic req_valid_in = 1'h0;
   logic req_ready_out;
   logic [19:0] req_addr_in = 20'h0;
   logic [7:0] req_lanes_in = 8'h0;
   logic [63:0] req_data_in = 64'h0;
   logic [7:0] req_parity_in = 8'h0;
   logic req_advance_in = 1'h0;
   logic stall_in = 1'h0;
   logic burst_order_in = 1'h1;
   logic read_en_n_in = 1'h0;
   logic [19:0] cur_addr_out;
   logic write_pulse_out;
   int n_fail = 0;
   int tests_run = 0;
   int n_wr = 0;
   logic [19:0] exp_a [$];
   logic [7:0] exp_s [$];
   sbsc_bus_if sbsc_bus_if_i ();
   sbsc_ctrl_end sbsc_ctrl_end_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_addr_in(req_addr_in),
      .req_lanes_in(req_lanes_in), .req_data_in(req_data_in), .req_parity_in(req_parity_in),
      .req_advance_in(req_advance_in), .stall_in(stall_in), .bus(sbsc_bus_if_i));
   sbsc_sram_end sbsc_sram_end_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .burst_order_in(burst_order_in), .read_en_n_in(read_en_n_in), .bus(sbsc_bus_if_i),
      .cur_addr_out(cur_addr_out), .write_pulse_out(write_pulse_out));
   sbsc_checker sbsc_checker_i (.clk_in(clk_in), .rstn_in(rstn_in),
      .clock_qualify_n(sbsc_bus_if_i.clock_qualify_n), .addr(sbsc_bus_if_i.addr),
      .advance_or_load_n(sbsc_bus_if_i.advance_or_load_n), .write_en_n(sbsc_bus_if_i.write_en_n),
      .chip_select_first_n(sbsc_bus_if_i.chip_select_first_n),
      .byte_write_sel_n(sbsc_bus_if_i.byte_write_sel_n),
      .data_from_sram(sbsc_bus_if_i.data_from_sram), .sram_drive_en(sbsc_bus_if_i.sram_drive_en));
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic push(input logic [19:0] a, input logic [7:0] l, input logic adv,
                       input logic [19:0] e);
      req_valid_in <= 1'h1;
      req_addr_in <= a;
      req_lanes_in <= l;
      req_data_in <= {8{l}};
      req_parity_in <= l;
      req_advance_in <= adv;
      @(posedge clk_in);
      while (req_ready_out !== 1'h1) @(posedge clk_in);
      exp_a.push_back(e);
      exp_s.push_back(~l);
   endtask
   task automatic do_reset(input logic ord);
      rstn_in <= 1'h0;
      burst_order_in <= ord;
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'h1;
      @(posedge clk_in);
      #1 chk(sbsc_bus_if_i.sram_drive_en, 8'h00);
      @(posedge clk_in);
      n_wr = 0;
   endtask
   task automatic drain(input int n);
      for (int i = 0; i < 200 && exp_a.size() > 0; i++) @(posedge clk_in);
      repeat (2) @(posedge clk_in);
      chk(exp_a.size(), 0);
      chk(n_wr, n);
      n_wr = 0;
   endtask
   // Every qualified selected edge is one write whose address the SRAM end must show.
   always @(posedge clk_in) begin
      if (write_pulse_out === 1'h1) n_wr++;
      if (rstn_in && !sbsc_bus_if_i.clock_qualify_n && !sbsc_bus_if_i.chip_select_first_n) begin
         chk(sbsc_bus_if_i.byte_write_sel_n, exp_s.pop_front());
         #1 chk(cur_addr_out, exp_a.pop_front());
      end
   end
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end
   initial begin
      for (int p = 1; p >= 0; p--) begin
         do_reset(p[0]);
         stall_in <= 1'h1;
         foreach (rows[i]) push(rows[i].a, rows[i].l, rows[i].adv, p ? rows[i].e_int : rows[i].e_lin);
         req_valid_in <= 1'h0;
         stall_in <= 1'h0;
         repeat (3) @(posedge clk_in);
         stall_in <= 1'h1;
         repeat (2) @(posedge clk_in);
         stall_in <= 1'h0;
         drain(6);
      end
      push(20'h00777, 8'h0f, 1'h1, 20'h00777);
      req_valid_in <= 1'h0;
      drain(1);
      stall_in <= 1'h1;
      for (int i = 0; i < SBSC_FIFO_DEPTH; i++) push(20'(i), 8'hff, 1'h0, 20'(i));
      req_valid_in <= 1'h0;
      @(posedge clk_in);
      chk(req_ready_out, 1'h0);
      stall_in <= 1'h0;
      drain(SBSC_FIFO_DEPTH);
      give_verdict();
   end
endmodule
